/* logic/wwf_pkg.sv */
/*
  Shared types and constants of the windowed watchdog: states, key codes,
  timebase steps, configuration and status carriers.
  Assumes a 10 MHz system clock.
*/
`default_nettype none

package wwf_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int WWF_CLK_PERIOD_NS = 100;
  localparam int WWF_FAST_STEP_NS = 8000;
  localparam int WWF_SLOW_STEP_NS = 64000;
  localparam int WWF_FAST_STEP_CYC = WWF_FAST_STEP_NS / WWF_CLK_PERIOD_NS;
  localparam int WWF_SLOW_STEP_CYC = WWF_SLOW_STEP_NS / WWF_CLK_PERIOD_NS;
  localparam int WWF_INIT_DEADLINE_MS = 500;
  localparam int WWF_INIT_DEADLINE_CYC =
    WWF_INIT_DEADLINE_MS * (1000000 / WWF_CLK_PERIOD_NS);
  localparam int WWF_RESET_HOLD_MS = 1;
  localparam int WWF_RESET_HOLD_CYC =
    WWF_RESET_HOLD_MS * (1000000 / WWF_CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Key codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] WWF_KEY_A = 2'h1;
  localparam logic [1:0] WWF_KEY_B = 2'h2;
  localparam logic WWF_SLOW_MODE_RST = 1'h0;
  localparam logic [7:0] WWF_MIN_TIME_RST = 8'h10;
  localparam logic [7:0] WWF_DELTA_TIME_RST = 8'h10;
  localparam logic [3:0] WWF_RETRY_THRESHOLD_RST = 4'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    idle_state,
    supervise_state,
    selftest_state,
    timed_reset_state,
    bypass_state
  } wwf_state_t;

  typedef struct packed {
    logic slow_mode;
    logic [7:0] window_min_time;
    logic [7:0] window_delta_time;
  } wwf_cfg_t;

  typedef struct packed {
    wwf_state_t state;
    logic [8:0] timer;
    logic [3:0] retry_counter;
    logic service_missed_flag;
    logic arming_lockout_latch;
    logic test_mode_indicator;
    logic disable_pin_state_bit;
    logic refresh_accepted;
    logic window_violation;
    logic reset_out;
  } wwf_status_t;

endpackage

`default_nettype wire

/* logic/wwf_watchdog.sv */
/*
  Windowed watchdog state machine with error/lockout latches, retry
  counter and fast/slow timebase.
  Assumes all inputs synchronous to clk; command inputs are one-cycle
  pulses decoded from SPI frames elsewhere.
*/
`timescale 1ns/100ps
`default_nettype none

module wwf_watchdog
  import wwf_pkg::*;
#(
  parameter int INIT_DEADLINE_CYC = WWF_INIT_DEADLINE_CYC,
  parameter int RESET_HOLD_CYC = WWF_RESET_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fsm_clear,
  input wire logic init_phase,
  input wire logic diag_entry,
  input wire logic cfg_wr,
  input wire wwf_cfg_t cfg_data,
  input wire logic thr_wr,
  input wire logic [3:0] thr_data,
  input wire logic refresh_wr,
  input wire logic [1:0] key_code_field,
  input wire logic test_activate_cmd,
  input wire logic override_wr,
  input wire logic timer_override_bit,
  input wire logic watchdog_disable_pin,
  output wwf_status_t status,
  output wwf_cfg_t cfg,
  output logic [3:0] retry_threshold,
  output logic retry_threshold_write_lock,
  output logic arm_enable
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    wwf_state_t state;
    logic [9:0] pre;
    logic [8:0] timer;
    logic [23:0] wait_cnt;
    logic got_a;
    logic got_b;
    logic missed;
    logic lockout;
    logic [3:0] retries;
    logic [3:0] thr;
    logic thr_lock;
    logic frozen;
    logic tovr;
    wwf_cfg_t cfg;
    logic accepted;
    logic violation;
  } wwf_regs_t;

  wwf_regs_t r;
  wwf_regs_t next_r;

  function automatic logic is_key(input logic [1:0] k);
    return (k == WWF_KEY_A) || (k == WWF_KEY_B);
  endfunction

  logic timing;
  logic tick;
  logic [9:0] step_last;
  logic [8:0] win_lo;
  logic [8:0] win_hi;
  logic late_now;
  logic early_now;
  logic done_now;
  logic err_now;
  logic [4:0] retries_inc;

  // ----------------------------------------------------------------------
  // Timebase and window checks
  // ----------------------------------------------------------------------
  assign step_last = r.cfg.slow_mode ? 10'(WWF_SLOW_STEP_CYC - 1)
                                     : 10'(WWF_FAST_STEP_CYC - 1);
  assign timing = (r.state == supervise_state ||
                   r.state == selftest_state) && !watchdog_disable_pin;
  assign tick = timing && (r.pre == step_last);
  assign win_lo = {1'b0, r.cfg.window_min_time};
  assign win_hi = win_lo + {1'b0, r.cfg.window_delta_time};
  assign late_now = timing && (r.timer > win_hi);
  assign early_now = timing && refresh_wr && is_key(key_code_field) &&
                     (r.timer < win_lo);
  // Pair completes on the complementary code, either order
  assign done_now = timing && refresh_wr && !early_now && !late_now &&
    ((key_code_field == WWF_KEY_A && r.got_b) ||
     (key_code_field == WWF_KEY_B && r.got_a));
  assign err_now = late_now || early_now ||
    (r.state == idle_state && !r.tovr && !watchdog_disable_pin &&
     r.wait_cnt == 24'(INIT_DEADLINE_CYC - 1));
  assign retries_inc = {1'b0, r.retries} + 5'h1;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.accepted = 1'b0;
    next_r.violation = 1'b0;
    if (cfg_wr && init_phase && !r.frozen) begin
      next_r.cfg = cfg_data;
    end
    if (diag_entry) begin
      next_r.frozen = 1'b1;
    end
    if (thr_wr && !r.thr_lock) begin
      next_r.thr = thr_data;
    end
    if (override_wr) begin
      next_r.tovr = timer_override_bit;
    end
    next_r.pre = tick ? 10'h0 : (timing ? r.pre + 10'h1 : 10'h0);
    if (watchdog_disable_pin) begin
      next_r.timer = 9'h0;
      next_r.wait_cnt = 24'h0;
    end else if (tick && r.timer != 9'h1ff) begin
      next_r.timer = r.timer + 9'h1;
    end
    case (r.state)
      idle_state: begin
        if (!r.tovr && !watchdog_disable_pin) begin
          next_r.wait_cnt = r.wait_cnt + 24'h1;
        end
        if (test_activate_cmd && watchdog_disable_pin) begin
          next_r.state = bypass_state;
        end else if (refresh_wr && is_key(key_code_field) && r.frozen) begin
          next_r.state = supervise_state; // Service begins
          next_r.thr_lock = 1'b1;
          next_r.timer = 9'h0;
          next_r.pre = 10'h0;
        end
      end
      supervise_state, selftest_state: begin
        if (refresh_wr && !err_now) begin
          if (key_code_field == WWF_KEY_A) begin
            next_r.got_a = 1'b1;
          end
          if (key_code_field == WWF_KEY_B) begin
            next_r.got_b = 1'b1;
          end
        end
        if (done_now) begin
          next_r.accepted = 1'b1;
          next_r.timer = 9'h0;
          next_r.pre = 10'h0;
          next_r.got_a = 1'b0;
          next_r.got_b = 1'b0;
          if (r.state == selftest_state) begin
            next_r.state = supervise_state;
          end
        end else if (test_activate_cmd && r.state == supervise_state &&
                     !err_now) begin
          next_r.state = selftest_state;
        end
      end
      timed_reset_state: begin
        next_r.wait_cnt = r.wait_cnt + 24'h1;
        if (r.wait_cnt == 24'(RESET_HOLD_CYC - 1)) begin
          next_r.state = supervise_state;
          // Any entry into run locks the threshold
          next_r.thr_lock = 1'b1;
          next_r.wait_cnt = 24'h0;
          next_r.timer = 9'h0;
        end
      end
      bypass_state: begin
        next_r.timer = 9'h0;
      end
      default: begin
        next_r.state = idle_state;
      end
    endcase
    if (err_now) begin
      next_r.violation = 1'b1;
      next_r.missed = 1'b1;
      next_r.state = timed_reset_state;
      next_r.wait_cnt = 24'h0;
      next_r.timer = 9'h0;
      next_r.got_a = 1'b0;
      next_r.got_b = 1'b0;
      // Test errors are expected ones: no count, no lockout
      if (r.state != selftest_state) begin
        if (r.retries != 4'hf) begin
          next_r.retries = retries_inc[3:0];
        end
        if (retries_inc > {1'b0, r.thr}) begin
          next_r.lockout = 1'b1;
        end
      end
    end
    if (fsm_clear) begin
      next_r.state = idle_state;
      next_r.pre = 10'h0;
      next_r.timer = 9'h0;
      next_r.wait_cnt = 24'h0;
      next_r.got_a = 1'b0;
      next_r.got_b = 1'b0;
      next_r.missed = 1'b0;
      next_r.lockout = 1'b0;
      next_r.retries = 4'h0;
      next_r.tovr = 1'b0;
      next_r.accepted = 1'b0;
      next_r.violation = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '{state: idle_state, pre: 10'h0, timer: 9'h0, wait_cnt: 24'h0,
             got_a: 1'b0, got_b: 1'b0, missed: 1'b0, lockout: 1'b0,
             retries: 4'h0, thr: WWF_RETRY_THRESHOLD_RST, thr_lock: 1'b0,
             frozen: 1'b0, tovr: 1'b0,
             cfg: '{slow_mode: WWF_SLOW_MODE_RST,
                    window_min_time: WWF_MIN_TIME_RST,
                    window_delta_time: WWF_DELTA_TIME_RST},
             accepted: 1'b0, violation: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign status.state = r.state;
  assign status.timer = r.timer;
  assign status.retry_counter = r.retries;
  assign status.service_missed_flag = r.missed;
  assign status.arming_lockout_latch = r.lockout;
  assign status.test_mode_indicator = (r.state == selftest_state);
  assign status.disable_pin_state_bit = watchdog_disable_pin;
  assign status.refresh_accepted = r.accepted;
  assign status.window_violation = r.violation;
  assign status.reset_out = (r.state == timed_reset_state);
  assign cfg = r.cfg;
  assign retry_threshold = r.thr;
  assign retry_threshold_write_lock = r.thr_lock;
  // Test state inhibits deployment; bypass emulates run
  assign arm_enable = (r.state == supervise_state ||
                       r.state == bypass_state) && !r.lockout;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  idle_arm_off_a: assert property (r.state == idle_state |-> !arm_enable)
    else $error("arming enabled in idle");
  lock_arm_off_a: assert property (r.lockout |-> !arm_enable)
    else $error("arming enabled under lockout");
  reset_exit_a: assert property (r.state == timed_reset_state &&
      r.wait_cnt == 24'(RESET_HOLD_CYC - 1) && !fsm_clear && !err_now
      |=> r.state == supervise_state)
    else $error("reset state not left on time");
  viol_latch_a: assert property (r.violation |-> r.missed &&
      r.state == timed_reset_state && status.reset_out)
    else $error("violation without latch or reset");
  accept_timer_a: assert property (done_now && !fsm_clear
      |=> r.accepted && r.timer == 9'h0 && !r.got_a && !r.got_b)
    else $error("accepted refresh did not restart window");
  wrong_key_a: assert property (refresh_wr && !is_key(key_code_field) &&
      !late_now && r.state != idle_state |=> !r.violation)
    else $error("wrong key raised error");
  clear_idle_a: assert property (fsm_clear |=> r.state == idle_state &&
      !r.lockout && !r.missed && !r.violation)
    else $error("state clear incomplete");
  disable_hold_a: assert property (watchdog_disable_pin
      |=> r.timer == 9'h0 && !r.violation)
    else $error("disable pin did not hold timer");
  thr_locked_a: assert property (r.thr_lock && thr_wr |=> $stable(r.thr))
    else $error("threshold changed after lock");
  test_entry_a: assert property (r.state == supervise_state &&
      test_activate_cmd && !err_now && !done_now && !fsm_clear
      |=> r.state == selftest_state)
    else $error("test command ignored in run");
  test_nolock_a: assert property (r.state == selftest_state && err_now
      && !fsm_clear |=> $stable(r.lockout) && $stable(r.retries))
    else $error("test error changed lockout");

  accept_c: cover property (r.accepted);
  violation_c: cover property (r.violation ##1 r.state == timed_reset_state);
  bypass_c: cover property (r.state == idle_state ##1 r.state == bypass_state);
  lockout_c: cover property ($rose(r.lockout));

endmodule // wwf_watchdog

`default_nettype wire

/* testbench/wwf_mcu_model.sv */
/*
  Microcontroller model: issues refresh-register writes with key codes.
  Assumes send_key is called at a falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module wwf_mcu_model
  import wwf_pkg::*;
(
  input wire logic clk,
  output logic refresh_wr,
  output logic [1:0] key_code_field
);
  initial begin
    refresh_wr = 1'h0;
    key_code_field = 2'h3;
  end

  // Released key line shows the inverse, never a stale key
  // Back-to-back writes keep the strobe up; the last one releases it
  task automatic send_key(input logic [1:0] k,
                          input logic more);
    refresh_wr = 1'h1;
    key_code_field = k;
    @(negedge clk);
    if (!more) begin
      refresh_wr = 1'h0;
      key_code_field = ~k;
    end
  endtask
endmodule // wwf_mcu_model

`default_nettype wire

/* testbench/tb_top.sv */
/*
  Self-checking bench of the windowed watchdog with a controller model.
  Assumes the short deadline and reset-hold parameters set below.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import wwf_pkg::*;
();
  localparam int INIT = 200;
  localparam int HOLD = 20;
  localparam logic [7:0] MIN = 8'h02;
  localparam logic [7:0] DEL = 8'h02;
  logic clk = 1'h0;
  logic rst, fsm_clear, init_phase, diag_entry, cfg_wr, thr_wr;
  logic test_activate_cmd, override_wr, timer_override_bit;
  logic watchdog_disable_pin, refresh_wr, lock_wr, arm_enable;
  logic [1:0] key_code_field;
  logic [3:0] thr_data, retry_threshold;
  wwf_cfg_t cfg_data, cfg;
  wwf_status_t st;
  logic [31:0] rng = 32'h0000a863;
  int miscompares = 0;
  int check_count = 0;
  int exp_retry = 0;
  int exp_thr = 2;
  logic exp_lock = 1'h0;

  always #50 clk = ~clk;

  wwf_watchdog #(.INIT_DEADLINE_CYC(INIT), .RESET_HOLD_CYC(HOLD)) dut_u (
    .clk(clk), .rst(rst), .fsm_clear(fsm_clear), .init_phase(init_phase),
    .diag_entry(diag_entry), .cfg_wr(cfg_wr), .cfg_data(cfg_data),
    .thr_wr(thr_wr), .thr_data(thr_data), .refresh_wr(refresh_wr),
    .key_code_field(key_code_field),
    .test_activate_cmd(test_activate_cmd), .override_wr(override_wr),
    .timer_override_bit(timer_override_bit),
    .watchdog_disable_pin(watchdog_disable_pin), .status(st), .cfg(cfg),
    .retry_threshold(retry_threshold),
    .retry_threshold_write_lock(lock_wr), .arm_enable(arm_enable));

  wwf_mcu_model mcu_u (.clk(clk), .refresh_wr(refresh_wr),
    .key_code_field(key_code_field));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic close_out();
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask

  task automatic wait_viol(input int lim);
    int n;
    n = 0;
    while (st.window_violation !== 1'h1 && n < lim) begin
      cyc(1);
      n++;
    end
    chk(st.window_violation, 1'h1);
  endtask

  // Waits for timer at or above t, bounded
  task automatic wait_tmr(input logic [8:0] t);
    int n;
    n = 0;
    while (!(st.timer >= t) && n < 2000) begin
      cyc(1);
      n++;
    end
    chk(n < 2000, 1'h1);
  endtask

  // Model update on an error, then walk the timed reset
  task automatic on_err(input logic counted);
    int n;
    if (counted) begin
      exp_retry++;
      exp_lock = exp_lock | (exp_retry > exp_thr);
    end
    chk(32'(st.state), 32'(timed_reset_state));
    chk(st.service_missed_flag, 1'h1);
    chk(st.retry_counter, exp_retry);
    chk(st.arming_lockout_latch, exp_lock);
    n = 0;
    while (st.reset_out === 1'h1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(n, HOLD);
    chk(st.service_missed_flag, 1'h1);
    chk(32'(st.state), 32'(supervise_state));
  endtask

  task automatic service(input logic [1:0] a, input logic [1:0] b);
    logic [31:0] r;
    r = next_rand();
    // Wrong key repeated while the window opens
    mcu_u.send_key(r[0] ? 2'h3 : 2'h0, 1'h1);
    chk(st.window_violation, 1'h0);
    wait_tmr(9'(MIN) + 9'(r[7:1] % 3));
    chk(st.window_violation, 1'h0);
    mcu_u.send_key(a, 1'h1);
    mcu_u.send_key(a, 1'h1);
    mcu_u.send_key(b, 1'h0);
    chk(st.refresh_accepted, 1'h1);
    chk(st.timer, 9'h000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    rst = 1'h1;
    {fsm_clear, diag_entry, cfg_wr, thr_wr, test_activate_cmd} = 5'h00;
    {override_wr, timer_override_bit, watchdog_disable_pin} = 3'h0;
    init_phase = 1'h1;
    cfg_data = '0;
    thr_data = 4'h0;
    cyc(10);
    rst = 1'h0;
    cyc(1);
    chk(32'(st.state), 32'(idle_state));
    chk(arm_enable, 1'h0);
    chk(cfg, {WWF_SLOW_MODE_RST, WWF_MIN_TIME_RST,
              WWF_DELTA_TIME_RST});
    chk(retry_threshold, WWF_RETRY_THRESHOLD_RST);
    // Threshold set before the deadline error first enters run
    thr_data = 4'h1;
    pulse(thr_wr);
    exp_thr = 1;
    wait_viol(INIT + 10);
    on_err(1'h1);
    pulse(fsm_clear);
    exp_retry = 0;
    chk(32'(st.state), 32'(idle_state));
    chk({st.service_missed_flag, st.retry_counter}, 5'h00);
    pulse(test_activate_cmd);
    chk(32'(st.state), 32'(idle_state));
    cfg_data = {1'h0, MIN, DEL};
    pulse(cfg_wr);
    // Run already entered after the deadline error: write refused
    thr_data = 4'h3;
    pulse(thr_wr);
    init_phase = 1'h0;
    pulse(diag_entry);
    init_phase = 1'h1;
    cfg_data = {1'h1, 8'h7f, 8'h7f};
    pulse(cfg_wr);
    chk(cfg, {1'h0, MIN, DEL});
    chk(retry_threshold, 4'h1);
    timer_override_bit = 1'h1;
    pulse(override_wr);
    cyc(INIT + 20);
    chk(32'(st.state), 32'(idle_state));
    mcu_u.send_key(WWF_KEY_A, 1'h0);
    chk(32'(st.state), 32'(supervise_state));
    chk({lock_wr, arm_enable}, 2'h3);
    thr_data = 4'h5;
    pulse(thr_wr);
    chk(retry_threshold, 4'h1);
    wait_tmr(9'h001);
    n = 0;
    while (st.timer === 9'h001 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk(n, WWF_FAST_STEP_CYC);
    service(WWF_KEY_A, WWF_KEY_B);
    service(WWF_KEY_B, WWF_KEY_A);
    cyc(1);
    mcu_u.send_key(WWF_KEY_B, 1'h0);
    wait_viol(3);
    on_err(1'h1);
    wait_viol((MIN + DEL + 2) * WWF_FAST_STEP_CYC);
    on_err(1'h1);
    chk(arm_enable, 1'h0);
    pulse(fsm_clear);
    exp_retry = 0;
    exp_lock = 1'h0;
    chk(st.arming_lockout_latch, 1'h0);
    mcu_u.send_key(WWF_KEY_A, 1'h0);
    pulse(test_activate_cmd);
    chk(32'(st.state), 32'(selftest_state));
    chk({st.test_mode_indicator, arm_enable}, 2'h2);
    service(WWF_KEY_A, WWF_KEY_B);
    chk(32'(st.state), 32'(supervise_state));
    chk(st.test_mode_indicator, 1'h0);
    pulse(test_activate_cmd);
    chk(32'(st.state), 32'(selftest_state));
    mcu_u.send_key(WWF_KEY_B, 1'h0);
    wait_viol(3);
    on_err(1'h0);
    pulse(fsm_clear);
    watchdog_disable_pin = 1'h1;
    cyc(1);
    chk(st.disable_pin_state_bit, 1'h1);
    pulse(test_activate_cmd);
    chk(32'(st.state), 32'(bypass_state));
    chk(arm_enable, 1'h1);
    cyc(INIT + 20);
    chk(32'(st.state), 32'(bypass_state));
    chk(st.service_missed_flag, 1'h0);
    // Second reset in bypass, then the slow timebase
    watchdog_disable_pin = 1'h0;
    rst = 1'h1;
    cyc(2);
    rst = 1'h0;
    cyc(1);
    chk(32'(st.state), 32'(idle_state));
    chk(lock_wr, 1'h0);
    cfg_data = {1'h1, MIN, DEL};
    pulse(cfg_wr);
    pulse(diag_entry);
    chk(cfg.slow_mode, 1'h1);
    mcu_u.send_key(WWF_KEY_A, 1'h0);
    wait_tmr(9'h001);
    n = 0;
    while (st.timer === 9'h001 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk(n, WWF_SLOW_STEP_CYC);
    close_out();
  end

  // Whole run needs a few thousand cycles
  initial begin
    cyc(20000);
    miscompares++;
    close_out();
  end
endmodule // tb_top

`default_nettype wire
